/* File: hw/lpmc_pkg.sv */
`default_nettype none
package lpmc_pkg;
    // Power modes held by the sequencer
    typedef enum logic [3:0] {
        LPMC_ACT_HI, LPMC_ACT_MED, LPMC_SLP_HI, LPMC_SLP_MED,
        LPMC_STBY, LPMC_WATCH, LPMC_SUBSLP, LPMC_SUBACT, LPMC_SETTLE
    } lpmc_mode_t;

    // Register word offsets (byte addresses)
    localparam logic [7:0] LPMC_SYSCTL_ONE = 8'h00;
    localparam logic [7:0] LPMC_SYSCTL_TWO = 8'h04;
    localparam logic [7:0] LPMC_IEN_TWO = 8'h08;
    localparam logic [7:0] LPMC_IRQ_EN = 8'h0c;
    localparam logic [7:0] LPMC_STATUS = 8'h10;

    // system_control_one fields
    localparam int LPMC_STANDBY_SELECT_BIT = 7;
    localparam int LPMC_STS_LSB = 4;
    localparam int LPMC_LOW_SPEED_ON_BIT = 3;
    localparam int LPMC_TMA_BIT = 2;
    localparam int LPMC_MA_LSB = 0;
    // system_control_two fields
    localparam int LPMC_DIRECT_TRANSFER_ON_BIT = 4;
    localparam int LPMC_MEDIUM_SPEED_ON_BIT = 3;
    localparam int LPMC_SA_LSB = 0;
    // interrupt_enable_two: direct transition enable
    localparam int LPMC_DTEN_BIT = 0;

    // Reset values
    localparam logic [7:0] LPMC_SYSCTL_ONE_RST = 8'h00;
    localparam logic [7:0] LPMC_SYSCTL_TWO_RST = 8'h00;
    localparam logic [7:0] LPMC_IEN_TWO_RST = 8'h00;

    // Clock gating and port controls for one mode
    typedef struct packed {
        logic sys_osc_en;
        logic cpu_run;
        logic periph_run;
        logic adc_pwm_run;
        logic watch_periph_run;
        logic io_hiz;
        logic io_hold;
    } lpmc_gate_t;

    // Control bits read on a sleep instruction; speed bits also read on wake from standby or watch
    typedef struct packed {
        logic standby_select;
        logic tma;
        logic low_speed_on;
        logic medium_speed_on;
        logic direct_transfer_on;
    } lpmc_sel_t;
endpackage
`default_nettype wire

/* File: hw/lpmc_top.sv */
`default_nettype none
module lpmc_top #(
    parameter int IRQ_W = 8,
    parameter int SETTLE_UNIT = 16
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rd_data,
    input wire logic sleep_exec,
    input wire logic [IRQ_W-1:0] irq_req,
    input wire logic interrupt_mask_flag,
    input wire logic reset_pin_n,
    input wire logic watchdog_osc_on,
    output lpmc_pkg::lpmc_gate_t gate,
    output logic cpu_reset,
    output logic [1:0] periph_div,
    output logic [1:0] sub_cpu_div,
    output logic exc_start,
    output logic direct_exc_start,
    output lpmc_pkg::lpmc_mode_t mode
);
    import lpmc_pkg::*;

    // Elaboration check; the largest settle wait must fit the 32-bit counter
    if (IRQ_W < 1 || IRQ_W > 8 || SETTLE_UNIT < 1 || SETTLE_UNIT > (1 << 24)) begin : g_bad_param
        $error("IRQ_W must be 1 to 8 and SETTLE_UNIT 1 to 2**24");
    end

    logic [7:0] sysctl_one; // system_control_one
    logic [7:0] sysctl_two; // system_control_two
    logic [7:0] ien_two; // interrupt_enable_two
    logic [IRQ_W-1:0] irq_en; // Per-source enables
    logic [IRQ_W-1:0] irq_s1; // Sync stage one
    logic [IRQ_W-1:0] irq_s2; // Sync stage two
    logic wake; // Qualified wake request
    logic direct_ok; // Direct transfer allowed
    lpmc_sel_t sel; // Current control bits
    lpmc_mode_t next_mode;
    lpmc_mode_t target; // Destination after transit
    lpmc_mode_t next_target;
    logic direct_pend; // Transit belongs to direct transfer
    logic next_direct_pend;
    logic [31:0] settle_cnt; // Remaining settle cycles
    logic next_exc;
    logic next_dexc;
    logic settle_load;

    // Settle time in cycles for a three-bit select
    function automatic logic [31:0] settle_cycles(input logic [2:0] s);
        settle_cycles = 32'(SETTLE_UNIT) << s;
    endfunction

    // Gating for each mode, watchdog may keep peripherals alive
    function automatic lpmc_gate_t gate_of(input lpmc_mode_t m, input logic wdt);
        lpmc_gate_t g;
        g = '{sys_osc_en: 1'b1, cpu_run: 1'b0, periph_run: 1'b1, adc_pwm_run: 1'b1,
              watch_periph_run: 1'b1, io_hiz: 1'b0, io_hold: 1'b0};
        case (m)
            LPMC_ACT_HI, LPMC_ACT_MED: g.cpu_run = 1'b1;
            LPMC_SLP_HI, LPMC_SLP_MED: g.cpu_run = 1'b0;
            LPMC_STBY: begin
                g.sys_osc_en = 1'b0;
                g.periph_run = wdt;
                g.adc_pwm_run = 1'b0;
                g.watch_periph_run = wdt;
                g.io_hiz = 1'b1;
            end
            LPMC_WATCH: begin
                g.sys_osc_en = 1'b0;
                g.periph_run = wdt;
                g.adc_pwm_run = 1'b0;
                g.io_hold = 1'b1;
            end
            LPMC_SUBSLP: begin
                g.sys_osc_en = 1'b0;
                g.adc_pwm_run = 1'b0;
                g.io_hold = 1'b1;
            end
            LPMC_SUBACT: begin
                g.sys_osc_en = 1'b0;
                g.cpu_run = 1'b1;
                g.adc_pwm_run = 1'b0;
            end
            LPMC_SETTLE: begin
                g.periph_run = 1'b0; // Oscillator restarting
                g.adc_pwm_run = 1'b0;
                g.watch_periph_run = wdt;
                g.io_hold = 1'b1;
            end
            default: g.cpu_run = 1'b1; // Unused codes behave as active
        endcase
        return g;
    endfunction

    // Fields of the control registers
    assign sel.standby_select = sysctl_one[LPMC_STANDBY_SELECT_BIT];
    assign sel.tma = sysctl_one[LPMC_TMA_BIT];
    assign sel.low_speed_on = sysctl_one[LPMC_LOW_SPEED_ON_BIT];
    assign sel.medium_speed_on = sysctl_two[LPMC_MEDIUM_SPEED_ON_BIT];
    assign sel.direct_transfer_on = sysctl_two[LPMC_DIRECT_TRANSFER_ON_BIT];

    // Two-stage sync of requests; wake looks only at stage two
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            irq_s1 <= '0;
            irq_s2 <= '0;
        end else begin
            irq_s1 <= irq_req;
            irq_s2 <= irq_s1;
        end
    end

    // Masked or disabled requests never wake the part
    assign wake = (|(irq_s2 & irq_en)) && !interrupt_mask_flag;
    // A masked direct transfer falls to sleep or watch and stays there
    assign direct_ok = sel.direct_transfer_on && ien_two[LPMC_DTEN_BIT] && !interrupt_mask_flag;

    // Register writes
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sysctl_one <= LPMC_SYSCTL_ONE_RST;
            sysctl_two <= LPMC_SYSCTL_TWO_RST;
            ien_two <= LPMC_IEN_TWO_RST;
            irq_en <= '0;
        end else if (wr_en) begin
            case (addr)
                LPMC_SYSCTL_ONE: sysctl_one <= wr_data;
                LPMC_SYSCTL_TWO: sysctl_two <= wr_data;
                LPMC_IEN_TWO: ien_two <= wr_data;
                LPMC_IRQ_EN: irq_en <= wr_data[IRQ_W-1:0];
                default: ; // Unmapped writes ignored
            endcase
        end
    end

    // Read data stands one cycle after the strobe; unmapped reads zero
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rd_data <= 8'h00;
        end else if (rd_en) begin
            case (addr)
                LPMC_SYSCTL_ONE: rd_data <= sysctl_one;
                LPMC_SYSCTL_TWO: rd_data <= sysctl_two;
                LPMC_IEN_TWO: rd_data <= ien_two;
                LPMC_IRQ_EN: rd_data <= 8'(irq_en);
                LPMC_STATUS: rd_data <= {4'h0, mode};
                default: rd_data <= 8'h00;
            endcase
        end else begin
            rd_data <= 8'h00;
        end
    end

    // Next mode decode
    always_comb begin
        next_mode = mode;
        next_target = target;
        next_direct_pend = direct_pend;
        next_exc = 1'b0;
        next_dexc = 1'b0;
        settle_load = 1'b0;
        case (mode)
            LPMC_ACT_HI, LPMC_ACT_MED: begin
                if (sleep_exec) begin
                    if (direct_ok && sel.standby_select && sel.tma && sel.low_speed_on) begin
                        next_mode = LPMC_WATCH;
                        next_target = LPMC_SUBACT;
                        next_direct_pend = 1'b1;
                    end else if (direct_ok && !sel.standby_select && !sel.low_speed_on) begin
                        // Speed change passes through sleep
                        next_mode = (mode == LPMC_ACT_HI) ? LPMC_SLP_HI : LPMC_SLP_MED;
                        next_target = sel.medium_speed_on ? LPMC_ACT_MED : LPMC_ACT_HI;
                        next_direct_pend = 1'b1;
                    end else if (!sel.standby_select) begin
                        next_mode = (mode == LPMC_ACT_HI) ? LPMC_SLP_HI : LPMC_SLP_MED;
                    end else if (sel.tma) begin
                        next_mode = LPMC_WATCH;
                    end else begin
                        next_mode = LPMC_STBY;
                    end
                end
            end
            LPMC_SUBACT: begin
                if (sleep_exec) begin
                    if (direct_ok && sel.standby_select && sel.tma && !sel.low_speed_on) begin
                        next_mode = LPMC_WATCH;
                        next_target = sel.medium_speed_on ? LPMC_ACT_MED : LPMC_ACT_HI;
                        next_direct_pend = 1'b1;
                    end else if (!sel.standby_select && sel.low_speed_on) begin
                        next_mode = LPMC_SUBSLP;
                    end else if (sel.standby_select && sel.tma) begin
                        next_mode = LPMC_WATCH;
                    end else begin
                        next_mode = LPMC_SUBSLP; // Other codes treated as subsleep
                    end
                end
            end
            LPMC_SLP_HI, LPMC_SLP_MED: begin
                if (direct_pend) begin
                    next_mode = target;
                    next_direct_pend = 1'b0;
                    next_dexc = 1'b1;
                end else if (wake) begin
                    next_mode = (mode == LPMC_SLP_HI) ? LPMC_ACT_HI : LPMC_ACT_MED;
                    next_exc = 1'b1;
                end
            end
            LPMC_SUBSLP: begin
                if (wake) begin
                    next_mode = LPMC_SUBACT;
                    next_exc = 1'b1;
                end
            end
            LPMC_STBY: begin
                if (wake) begin
                    next_mode = LPMC_SETTLE;
                    next_target = sel.medium_speed_on ? LPMC_ACT_MED : LPMC_ACT_HI;
                    settle_load = 1'b1;
                end
            end
            LPMC_WATCH: begin
                if (direct_pend && target == LPMC_SUBACT) begin
                    next_mode = LPMC_SUBACT;
                    next_direct_pend = 1'b0;
                    next_dexc = 1'b1;
                end else if (direct_pend) begin
                    next_mode = LPMC_SETTLE;
                    settle_load = 1'b1;
                end else if (wake && sel.low_speed_on) begin
                    next_mode = LPMC_SUBACT;
                    next_exc = 1'b1;
                end else if (wake) begin
                    next_mode = LPMC_SETTLE;
                    next_target = sel.medium_speed_on ? LPMC_ACT_MED : LPMC_ACT_HI;
                    settle_load = 1'b1;
                end
            end
            LPMC_SETTLE: begin
                if (settle_cnt == 32'h0000_0001) begin
                    next_mode = target;
                    next_exc = !direct_pend;
                    next_dexc = direct_pend;
                    next_direct_pend = 1'b0;
                end
            end
            default: begin
                next_mode = LPMC_ACT_HI;
            end
        endcase
        // Pin reset overrides every mode
        if (!reset_pin_n) begin
            next_mode = LPMC_ACT_HI;
            next_direct_pend = 1'b0;
            next_exc = 1'b0;
            next_dexc = 1'b0;
            settle_load = 1'b0;
        end
    end

    // Mode and transit state
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            mode <= LPMC_ACT_HI;
            target <= LPMC_ACT_HI;
            direct_pend <= 1'b0;
        end else begin
            mode <= next_mode;
            target <= next_target;
            direct_pend <= next_direct_pend;
        end
    end

    // Settle counter, loaded as the oscillator restarts
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            settle_cnt <= 32'h0;
        end else if (settle_load) begin
            settle_cnt <= settle_cycles(sysctl_one[LPMC_STS_LSB +: 3]);
        end else if (settle_cnt != 32'h0) begin
            settle_cnt <= settle_cnt - 32'h1;
        end
    end

    // Exception pulses, one cycle each
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            exc_start <= 1'b0;
            direct_exc_start <= 1'b0;
        end else begin
            exc_start <= next_exc;
            direct_exc_start <= next_dexc;
        end
    end

    // CPU reset follows pin; oscillator forced on meanwhile
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cpu_reset <= 1'b1;
        end else begin
            cpu_reset <= !reset_pin_n;
        end
    end

    // Clock gating registered from the next mode
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            gate <= '{io_hiz: 1'b0, io_hold: 1'b0, default: 1'b1}; // Active high-speed pattern
        end else begin
            gate <= gate_of(next_mode, watchdog_osc_on);
            if (!reset_pin_n) begin
                gate.sys_osc_en <= 1'b1;
            end
        end
    end

    // Peripheral divider only in medium-speed modes
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            periph_div <= 2'h0;
        end else if (next_mode == LPMC_ACT_MED || next_mode == LPMC_SLP_MED) begin
            periph_div <= sysctl_one[LPMC_MA_LSB +: 2];
        end else begin
            periph_div <= 2'h0;
        end
    end

    // Subactive divider latched at sleep so writes apply later
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sub_cpu_div <= 2'h0;
        end else if (sleep_exec) begin
            sub_cpu_div <= sysctl_two[LPMC_SA_LSB +: 2];
        end
    end
endmodule // lpmc_top
`default_nettype wire

/* File: test/lpmc_props.sv */
`default_nettype none
module lpmc_props
    import lpmc_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_en,
    input wire logic sleep_exec,
    input wire logic interrupt_mask_flag,
    input wire logic reset_pin_n,
    input wire lpmc_pkg::lpmc_gate_t gate,
    input wire logic cpu_reset,
    input wire logic [1:0] periph_div,
    input wire logic direct_exc_start,
    input wire lpmc_pkg::lpmc_mode_t mode
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] one_q; // Copy of system_control_one
    logic [7:0] two_q; // Copy of system_control_two
    logic dten_q; // Copy of direct transition enable
    logic in_slp;
    logic in_med;
    logic low_pwr;
    logic dir_ok;
    // Shadow the control bits as the bus writes them
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            one_q <= 8'h00;
            two_q <= 8'h00;
            dten_q <= 1'b0;
        end else if (wr_en) begin
            if (addr == LPMC_SYSCTL_ONE) one_q <= wr_data;
            if (addr == LPMC_SYSCTL_TWO) two_q <= wr_data;
            if (addr == LPMC_IEN_TWO) dten_q <= wr_data[LPMC_DTEN_BIT];
        end
    end
    assign in_slp = mode == LPMC_SLP_HI || mode == LPMC_SLP_MED;
    assign in_med = mode == LPMC_ACT_MED || mode == LPMC_SLP_MED;
    // Settle is left out: it ends on its own count
    assign low_pwr = in_slp || mode == LPMC_STBY || mode == LPMC_WATCH || mode == LPMC_SUBSLP;
    assign dir_ok = two_q[LPMC_DIRECT_TRANSFER_ON_BIT] && dten_q && !interrupt_mask_flag;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);
    // Direct request from high-speed towards medium-speed
    sequence s_hi_to_med;
        mode == LPMC_ACT_HI && sleep_exec && dir_ok && !one_q[LPMC_STANDBY_SELECT_BIT] && !one_q[LPMC_LOW_SPEED_ON_BIT]
            && two_q[LPMC_MEDIUM_SPEED_ON_BIT];
    endsequence
    // One sleep cycle, then medium-speed with the direct pulse
    sequence s_via_slp;
        mode == LPMC_SLP_HI ##1 mode == LPMC_ACT_MED && direct_exc_start;
    endsequence
    a_sleep_halts_cpu: assert property (
        in_slp |-> !gate.cpu_run && gate.sys_osc_en && gate.periph_run) else $error("CPU runs in sleep");
    a_med_div_sel: assert property (
        in_med && !$past(wr_en) |-> periph_div == one_q[1:0]) else $error("Wrong peripheral divider");
    a_masked_stays: assert property (
        low_pwr && interrupt_mask_flag && reset_pin_n |=> mode == $past(mode)) else $error("Masked wake left mode");
    a_pin_reset: assert property (
        !reset_pin_n |=> mode == LPMC_ACT_HI && cpu_reset) else $error("Pin reset not taken");
    a_stby_gates: assert property (
        mode == LPMC_STBY |-> !gate.sys_osc_en && gate.io_hiz) else $error("Standby gating wrong");
    a_watch_gates: assert property (
        mode == LPMC_WATCH |-> !gate.cpu_run && gate.io_hold && gate.watch_periph_run) else $error("Watch gating wrong");
    a_subact_only_sleep: assert property (
        mode == LPMC_SUBACT && !sleep_exec && reset_pin_n |=> mode == LPMC_SUBACT) else $error("Subactive left");
    a_direct_via_sleep: assert property (
        s_hi_to_med |=> s_via_slp) else $error("Direct change to medium speed wrong");
endmodule // lpmc_props
`default_nettype wire

/* File: test/lpmc_cpu_model.sv */
`default_nettype none
module lpmc_cpu_model
    import lpmc_pkg::*;
#(
    parameter int IRQ_W = 8,
    parameter int STABLE_CYC = 4
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [IRQ_W-1:0] irq_set,
    input wire logic pin_req,
    input wire logic exc_start,
    input wire lpmc_pkg::lpmc_gate_t gate,
    output logic [IRQ_W-1:0] irq_req,
    output logic reset_pin_n
);
    timeunit 1ns;
    timeprecision 1ps;
    int stab; // Cycles the oscillator has run
    // Pending requests; taken exception or pin reset drops them
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) irq_req <= '0;
        else if (exc_start || !reset_pin_n) irq_req <= irq_set;
        else irq_req <= irq_req | irq_set;
    end
    // Pin kept low until the oscillator is stable
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            stab <= 0;
            reset_pin_n <= 1'b1;
        end else begin
            stab <= gate.sys_osc_en ? stab + 1 : 0;
            if (pin_req) reset_pin_n <= 1'b0;
            else if (stab >= STABLE_CYC) reset_pin_n <= 1'b1;
        end
    end
endmodule // lpmc_cpu_model
`default_nettype wire

/* File: test/low_power_mode_controller_bench.sv */
`default_nettype none
`define CHK(n, e, v) begin checks++; if ((v) !== (e)) begin errors++; $display("Error %s exp %h got %h", n, e, v); end end
module low_power_mode_controller_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import lpmc_pkg::*;
    localparam int IW = 4;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wr_data = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic sleep_exec = 1'b0;
    logic interrupt_mask_flag = 1'b0;
    logic [IW-1:0] irq_set = '0;
    logic pin_req = 1'b0;
    logic watchdog_osc_on = 1'b0; // Watchdog keeps on-chip oscillator
    logic [7:0] rd_data;
    logic [IW-1:0] irq_req;
    logic reset_pin_n;
    lpmc_gate_t gate;
    logic cpu_reset;
    logic [1:0] periph_div;
    logic [1:0] sub_cpu_div;
    logic exc_start;
    logic direct_exc_start;
    lpmc_mode_t mode;
    int errors = 0;
    int checks = 0;
    int cyc = 0;
    int seed = 32'h31e6;
    int s; // Settle select
    int ma; // Peripheral divider
    int sa; // Subactive divider
    logic [5:0] q[$]; // Expected {exc, direct, mode} per cycle
    lpmc_top #(.IRQ_W(IW), .SETTLE_UNIT(1)) lpmc_top_inst (.core_clk(core_clk), .resetn(resetn), .addr(addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .sleep_exec(sleep_exec),
        .irq_req(irq_req), .interrupt_mask_flag(interrupt_mask_flag), .reset_pin_n(reset_pin_n),
        .watchdog_osc_on(watchdog_osc_on), .gate(gate), .cpu_reset(cpu_reset), .periph_div(periph_div),
        .sub_cpu_div(sub_cpu_div), .exc_start(exc_start), .direct_exc_start(direct_exc_start), .mode(mode));
    lpmc_cpu_model #(.IRQ_W(IW)) lpmc_cpu_model_inst (.core_clk(core_clk), .resetn(resetn), .irq_set(irq_set),
        .pin_req(pin_req), .exc_start(exc_start), .gate(gate), .irq_req(irq_req), .reset_pin_n(reset_pin_n));
    always #4 core_clk = ~core_clk;
    // Hang guard
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    function automatic logic [7:0] c1(logic sb, logic ls, logic tm);
        return {sb, s[2:0], ls, tm, ma[1:0]};
    endfunction
    function automatic logic [7:0] c2(logic dt, logic ms);
        return {3'b000, dt, ms, 1'b0, sa[1:0]};
    endfunction
    task automatic push(lpmc_mode_t m, int n, logic [1:0] x = 2'b00);
        repeat (n) q.push_back({x, m});
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge core_clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge core_clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] e);
        @(posedge core_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge core_clk);
        rd_en <= 1'b0;
        #1;
        `CHK("rd_data", e, rd_data)
    endtask
    // Compare every following cycle against the model queue
    task automatic walk();
        logic [5:0] e;
        while (q.size() > 0) begin
            @(posedge core_clk);
            sleep_exec <= 1'b0;
            irq_set <= '0;
            #1;
            e = q.pop_front();
            `CHK("mode", e, {exc_start, direct_exc_start, mode})
        end
    endtask
    task automatic slp(logic [7:0] one, logic [7:0] two);
        wr(LPMC_SYSCTL_ONE, one);
        wr(LPMC_SYSCTL_TWO, two);
        @(posedge core_clk);
        sleep_exec <= 1'b1;
        walk();
    endtask
    task automatic fire(logic [IW-1:0] b, logic m, logic p);
        @(posedge core_clk);
        irq_set <= b;
        interrupt_mask_flag <= m;
        pin_req <= p;
        watchdog_osc_on <= 1'b0;
        walk();
    endtask
    initial begin
        s = $random(seed) & 7;
        ma = $random(seed) & 3;
        sa = $random(seed) & 1;
        repeat (12) @(posedge core_clk);
        resetn <= 1'b1;
        rd(LPMC_SYSCTL_ONE, LPMC_SYSCTL_ONE_RST);
        rd(LPMC_SYSCTL_TWO, LPMC_SYSCTL_TWO_RST);
        rd(LPMC_IEN_TWO, LPMC_IEN_TWO_RST);
        rd(8'h20, 8'h00);
        rd(LPMC_STATUS, 8'h00);
        wr(LPMC_IRQ_EN, 8'h01);
        wr(LPMC_IEN_TWO, 8'h01);
        push(LPMC_SLP_HI, 1);
        slp(c1(0, 0, 0), c2(0, 0));
        push(LPMC_SLP_HI, 8);
        fire(4'h2, 0, 0);
        push(LPMC_SLP_HI, 3);
        push(LPMC_ACT_HI, 1, 2'b10);
        fire(4'h1, 0, 0);
        push(LPMC_SLP_HI, 1);
        push(LPMC_ACT_MED, 1, 2'b01);
        slp(c1(0, 0, 0), c2(1, 1));
        `CHK("periph_div", ma[1:0], periph_div)
        push(LPMC_SLP_MED, 1);
        slp(c1(0, 0, 0), c2(0, 1));
        push(LPMC_SLP_MED, 10);
        fire(4'h1, 1, 0);
        push(LPMC_ACT_MED, 1, 2'b10);
        fire(4'h0, 0, 0);
        push(LPMC_SLP_MED, 1);
        push(LPMC_ACT_HI, 1, 2'b01);
        slp(c1(0, 0, 0), c2(1, 0));
        push(LPMC_STBY, 1);
        slp(c1(1, 0, 0), c2(0, 1));
        @(posedge core_clk);
        watchdog_osc_on <= 1'b1;
        push(LPMC_STBY, 1);
        walk();
        `CHK("gate", 4'b0111, {gate.sys_osc_en, gate.periph_run, gate.watch_periph_run, gate.io_hiz})
        push(LPMC_STBY, 3);
        push(LPMC_SETTLE, 1 << s);
        push(LPMC_ACT_MED, 1, 2'b10);
        fire(4'h1, 0, 0);
        push(LPMC_WATCH, 1);
        push(LPMC_SUBACT, 1, 2'b01);
        slp(c1(1, 1, 1), c2(1, 1));
        `CHK("sub_cpu_div", sa[1:0], sub_cpu_div)
        `CHK("gate", 3'b100, {gate.cpu_run, gate.sys_osc_en, gate.adc_pwm_run})
        sa = sa + 1;
        wr(LPMC_SYSCTL_TWO, c2(0, 0));
        `CHK("sub_cpu_div", 2'(sa - 1), sub_cpu_div)
        push(LPMC_SUBSLP, 1);
        slp(c1(0, 1, 0), c2(0, 0));
        `CHK("gate", 2'b01, {gate.cpu_run, gate.adc_pwm_run} ^ 2'b01)
        push(LPMC_SUBSLP, 3);
        push(LPMC_SUBACT, 1, 2'b10);
        fire(4'h1, 0, 0);
        `CHK("sub_cpu_div", sa[1:0], sub_cpu_div)
        push(LPMC_WATCH, 1);
        slp(c1(1, 1, 1), c2(0, 0));
        push(LPMC_WATCH, 3);
        push(LPMC_SUBACT, 1, 2'b10);
        fire(4'h1, 0, 0);
        push(LPMC_WATCH, 1);
        push(LPMC_SETTLE, 1 << s);
        push(LPMC_ACT_MED, 1, 2'b01);
        slp(c1(1, 0, 1), c2(1, 1));
        rd(LPMC_SYSCTL_ONE, c1(1, 0, 1));
        wr(LPMC_IEN_TWO, 8'h00);
        push(LPMC_SLP_MED, 1);
        slp(c1(0, 0, 0), c2(1, 1));
        push(LPMC_SLP_MED, 3);
        push(LPMC_ACT_MED, 1, 2'b10);
        fire(4'h1, 0, 0);
        wr(LPMC_IEN_TWO, 8'h01);
        @(posedge core_clk);
        interrupt_mask_flag <= 1'b1;
        push(LPMC_WATCH, 1);
        slp(c1(1, 0, 1), c2(1, 1));
        push(LPMC_WATCH, 10);
        fire(4'h1, 1, 0);
        push(LPMC_WATCH, 1);
        push(LPMC_ACT_HI, 1);
        fire(4'h0, 1, 1);
        `CHK("cpu_reset", 1'b1, cpu_reset)
        push(LPMC_ACT_HI, 8);
        fire(4'h0, 0, 0);
        `CHK("cpu_reset", 1'b0, cpu_reset)
        stop_test();
    end
endmodule // low_power_mode_controller_bench
bind lpmc_top lpmc_props lpmc_props_inst (.core_clk(core_clk), .resetn(resetn), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .sleep_exec(sleep_exec), .interrupt_mask_flag(interrupt_mask_flag), .reset_pin_n(reset_pin_n),
    .gate(gate), .cpu_reset(cpu_reset), .periph_div(periph_div), .direct_exc_start(direct_exc_start), .mode(mode));
`default_nettype wire
